// File: rtl/ctm_pkg.sv
package ctm_pkg;
	// Register byte addresses on the Wishbone bus
	localparam logic [4:0] CTM_OFF_CTRL0 = 5'h00;
	localparam logic [4:0] CTM_OFF_CTRL1 = 5'h04;
	localparam logic [4:0] CTM_OFF_CNTL = 5'h08;
	localparam logic [4:0] CTM_OFF_CNTH = 5'h0c;
	localparam logic [4:0] CTM_OFF_CMPAL = 5'h10;
	localparam logic [4:0] CTM_OFF_CMPAH = 5'h14;
	localparam logic [4:0] CTM_OFF_STAT = 5'h18;
	// Values after reset
	localparam logic [7:0] CTM_RST_CTRL0 = 8'h00;
	localparam logic [7:0] CTM_RST_CTRL1 = 8'h00;
	localparam logic [9:0] CTM_RST_CMPA = 10'h000;
	// Counter geometry
	localparam int CTM_CNT_W = 10;
	localparam logic [9:0] CTM_CNT_MAX = 10'h3ff;
	localparam logic [10:0] CTM_FULL_SPAN = 11'h400;
	localparam int CTM_P_SHIFT = 7;
	// Status field positions
	localparam int CTM_STAT_A_BIT = 0;
	localparam int CTM_STAT_P_BIT = 1;
	// Clock divider terminal counts
	localparam logic [1:0] CTM_SYS_DIV_LAST = 2'h3;
	localparam logic [3:0] CTM_HS16_LAST = 4'hf;
	localparam logic [5:0] CTM_HS64_LAST = 6'h3f;
	// Clock source codes
	localparam logic [2:0] CTM_CK_SYS4 = 3'h0;
	localparam logic [2:0] CTM_CK_SYS = 3'h1;
	localparam logic [2:0] CTM_CK_HS16 = 3'h2;
	localparam logic [2:0] CTM_CK_HS64 = 3'h3;
	localparam logic [2:0] CTM_CK_TB = 3'h4;
	localparam logic [2:0] CTM_CK_NONE = 3'h5;
	localparam logic [2:0] CTM_CK_EXT_R = 3'h6;
	localparam logic [2:0] CTM_CK_EXT_F = 3'h7;
	// Output action codes
	localparam logic [1:0] CTM_IO_KEEP = 2'h0;
	localparam logic [1:0] CTM_IO_LOW = 2'h1;
	localparam logic [1:0] CTM_IO_HIGH = 2'h2;
	localparam logic [1:0] CTM_IO_TOGGLE = 2'h3;
	// Operating modes
	typedef enum logic [1:0] {
		CTM_MODE_CMP = 2'b00,
		CTM_MODE_UNDEF = 2'b01,
		CTM_MODE_PWM = 2'b10,
		CTM_MODE_TMR = 2'b11
	} ctm_mode_t;
	// First control register layout
	typedef struct packed {
		logic pause;
		logic [2:0] clk_sel;
		logic on;
		logic [2:0] period_match_bits;
	} ctm_ctrl0_t;
	// Second control register layout
	typedef struct packed {
		ctm_mode_t mode;
		logic [1:0] action;
		logic init_level;
		logic invert;
		logic duty_swap;
		logic clear_sel;
	} ctm_ctrl1_t;
	// Edge pulses from the external count input
	typedef struct packed {
		logic rise;
		logic fall;
	} ctm_edge_t;
endpackage : ctm_pkg

// File: rtl/ctm_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ctm_edge_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous pin
	input wire logic pin_i,
	// Edge pulses
	output ctm_pkg::ctm_edge_t edge_o
);
	import ctm_pkg::*;
	logic meta_r; // First stage, read only by the second
	logic sync_r; // Second stage, safe to use
	logic prev_r; // Delayed copy for edge detection

	// Two-stage synchroniser, then one more stage for the edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// one pulse per edge
	// One assignment drives the whole struct, rise then fall
	assign edge_o = {sync_r & ~prev_r, ~sync_r & prev_r};
endmodule : ctm_edge_sync
`default_nettype wire

// File: rtl/ctm_tick_sel.sv
`timescale 1ns/10ps
`default_nettype none
module ctm_tick_sel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Source selection and raw enables
	input wire logic [2:0] sel_i,
	input wire logic hs_tick_i,
	input wire logic tb_tick_i,
	input wire ctm_pkg::ctm_edge_t ext_i,
	// Selected count enable
	output logic tick_o
);
	import ctm_pkg::*;
	logic [1:0] sys_div_r; // Free-running divide by four
	logic [5:0] hs_div_r; // Counts high speed ticks

	// Dividers run always, so a source switch never waits for a restart
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_div_r <= 2'h0;
			hs_div_r <= 6'h00;
		end else begin
			sys_div_r <= sys_div_r + 2'h1;
			if (hs_tick_i) begin
				hs_div_r <= hs_div_r + 6'h01;
			end
		end
	end

	// Source multiplexer
	always_comb begin
		case (sel_i)
			CTM_CK_SYS4: tick_o = (sys_div_r == CTM_SYS_DIV_LAST);
			CTM_CK_SYS: tick_o = 1'b1;
			CTM_CK_HS16: tick_o = hs_tick_i && (hs_div_r[3:0] == CTM_HS16_LAST);
			CTM_CK_HS64: tick_o = hs_tick_i && (hs_div_r == CTM_HS64_LAST);
			CTM_CK_TB: tick_o = tb_tick_i;
			CTM_CK_EXT_R: tick_o = ext_i.rise;
			CTM_CK_EXT_F: tick_o = ext_i.fall;
			default: tick_o = 1'b0;
		endcase
	end
endmodule : ctm_tick_sel
`default_nettype wire

// File: rtl/ctm_top.sv
// Function
// - Ten-bit up counter on selected clock
// - Comparator P checks counter bits nine to seven
// - Comparator A checks all ten bits
// - Software clears counter only via enable rise
// - Overflow or selected match clears counter
// - Pause holds value, resume continues
// - Clock source select codes
// - Code 101 gives no count clock
// - Enable rise clears and runs, fall holds
// - Enable rise restores initial output level in compare mode
// - P period is code times 128, zero 1024
// - P match clears when clear select zero
// - P code zero clears by overflow
// - Mode codes: compare, PWM, timer
// - A match pin action: keep, low, high, toggle
// - Action equal to initial level, no change
// - PWM action: inactive, active, waveform
// - Initial level or PWM active level
// - Invert flips pin, not in timer mode
// - Swap exchanges PWM period and duty roles
// - Clear select picks A or P/overflow
// - Low bytes pass through byte buffer
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ctm_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Count sources
	input wire logic hs_tick_i,
	input wire logic tb_tick_i,
	input wire logic external_count_input_i,
	// Timer pins and events
	output logic output_pin_zero_o,
	output logic output_pin_one_o,
	output logic [1:0] match_flags_o
);
	import ctm_pkg::*;
	ctm_ctrl0_t ctrl0_r; // Clock, enable, pause, P code
	ctm_ctrl1_t ctrl1_r; // Mode and output setup
	logic [9:0] cnt_r; // The counter
	logic [9:0] cmpa_r; // Committed compare A value
	logic [7:0] cnt_buf_r; // Low byte buffer for counter reads
	logic [7:0] cmpa_buf_r; // Low byte buffer for compare A
	logic on_prev_r; // Enable of the previous cycle
	logic lvl_r; // Logical output level before inversion
	logic a_flag_r; // Sticky compare A event
	logic p_flag_r; // Sticky compare P event
	ctm_edge_t ext_edge; // Synchronised external edges
	logic tick; // Selected count enable
	logic on_rise; // Enable went low to high
	logic run; // Counter advances this cycle
	logic [10:0] cnt_inc; // Counter plus one, carry kept
	logic [10:0] p_span; // P match point in count clocks
	logic [10:0] pwm_period; // PWM period in count clocks
	logic [10:0] pwm_duty; // PWM duty in count clocks
	logic p_hit; // Comparator P match
	logic a_hit; // Comparator A match
	logic ovf; // Counter wraps past maximum
	logic clr; // Counter clears on this tick
	logic p_ev; // Event that sets the P flag
	logic pwm_act; // PWM waveform in its active phase
	logic pwm_lvl; // PWM pin level before inversion
	logic pin_nxt; // Next pin level
	logic bus_req; // New bus request this cycle
	logic [31:0] rd_nxt; // Read data for the answer

	// Register index decode shared by reads and writes
	function automatic logic is_reg(input logic [4:0] adr, input logic [4:0] off);
		is_reg = (adr[4:2] == off[4:2]);
	endfunction : is_reg
	// External pin synchroniser and edge detector
	ctm_edge_sync u_edge (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(external_count_input_i),
		.edge_o(ext_edge)
	);
	// Count clock selection and prescaling
	ctm_tick_sel u_tick (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sel_i(ctrl0_r.clk_sel),
		.hs_tick_i(hs_tick_i),
		.tb_tick_i(tb_tick_i),
		.ext_i(ext_edge),
		.tick_o(tick)
	);
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign on_rise = ctrl0_r.on && !on_prev_r;
	// pause and off both stop the count
	assign run = tick && ctrl0_r.on && !ctrl0_r.pause && !on_rise;
	assign cnt_inc = {1'b0, cnt_r} + 11'h001;
	// code zero means the full span
	assign p_span = (ctrl0_r.period_match_bits == 3'h0) ? CTM_FULL_SPAN :
		{1'b0, ctrl0_r.period_match_bits, 7'h00};
	// Match detection and counter clear selection
	always_comb begin
		pwm_period = p_span;
		pwm_duty = {1'b0, cmpa_r};
		if (ctrl1_r.duty_swap) begin
			pwm_period = (cmpa_r == 10'h000) ? CTM_FULL_SPAN : {1'b0, cmpa_r};
			pwm_duty = p_span;
		end
		p_hit = run && (cnt_inc[9:CTM_P_SHIFT] == ctrl0_r.period_match_bits) &&
			(cnt_inc[6:0] == 7'h00) && (ctrl0_r.period_match_bits != 3'h0) && !cnt_inc[10];
		a_hit = run && (cnt_inc[9:0] == cmpa_r) && (cmpa_r != 10'h000) && !cnt_inc[10];
		ovf = run && (cnt_r == CTM_CNT_MAX);
		case (ctrl1_r.mode)
			CTM_MODE_PWM: begin
				// Clear select is ignored here
				clr = run && (cnt_inc == pwm_period);
				p_ev = run && (cnt_inc == p_span);
			end
			default: begin
				// A match or P match and overflow
				if (ctrl1_r.clear_sel) begin
					clr = a_hit || ovf;
					p_ev = 1'b0;
				end else begin
					clr = p_hit || ovf;
					p_ev = p_hit || (ovf && (ctrl0_r.period_match_bits == 3'h0));
				end
			end
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 10'h000;
			on_prev_r <= 1'b0;
		end else begin
			on_prev_r <= ctrl0_r.on;
			if (on_rise) begin
				cnt_r <= 10'h000;
			end else if (clr) begin
				cnt_r <= 10'h000;
			end else if (run) begin
				cnt_r <= cnt_inc[9:0];
			end
		end
	end

	// Sticky match flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_flag_r <= 1'b0;
			p_flag_r <= 1'b0;
		end else begin
			if (a_hit) begin
				a_flag_r <= 1'b1;
			end else if (bus_req && wb_we_i && wb_sel_i[0] && is_reg(wb_adr_i, CTM_OFF_STAT) &&
				wb_dat_i[CTM_STAT_A_BIT]) begin
				a_flag_r <= 1'b0;
			end
			if (p_ev) begin
				p_flag_r <= 1'b1;
			end else if (bus_req && wb_we_i && wb_sel_i[0] && is_reg(wb_adr_i, CTM_OFF_STAT) &&
				wb_dat_i[CTM_STAT_P_BIT]) begin
				p_flag_r <= 1'b0;
			end
		end
	end

	// Compare-match output level
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lvl_r <= 1'b0;
		end else if (ctrl1_r.mode == CTM_MODE_CMP) begin
			if (on_rise) begin
				lvl_r <= ctrl1_r.init_level;
			end else if (a_hit) begin
				// same level as now leaves pin unchanged
				case (ctrl1_r.action)
					CTM_IO_LOW: lvl_r <= 1'b0;
					CTM_IO_HIGH: lvl_r <= 1'b1;
					CTM_IO_TOGGLE: lvl_r <= ~lvl_r;
					default: lvl_r <= lvl_r;
				endcase
			end
		end
	end

	// PWM level; duty at or beyond the period gives a full active phase
	always_comb begin
		pwm_act = ({1'b0, cnt_r} < pwm_duty);
		// init level is the active level
		case (ctrl1_r.action)
			CTM_IO_LOW: pwm_lvl = ctrl1_r.init_level;
			CTM_IO_HIGH: pwm_lvl = pwm_act ? ctrl1_r.init_level : ~ctrl1_r.init_level;
			default: pwm_lvl = ~ctrl1_r.init_level;
		endcase
		case (ctrl1_r.mode)
			CTM_MODE_CMP: pin_nxt = lvl_r ^ ctrl1_r.invert;
			CTM_MODE_PWM: pin_nxt = pwm_lvl ^ ctrl1_r.invert;
			default: pin_nxt = 1'b0;
		endcase
	end

	// Pin outputs, registered; pin one is the complement when in use
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			output_pin_zero_o <= 1'b0;
			output_pin_one_o <= 1'b0;
			match_flags_o <= 2'h0;
		end else begin
			output_pin_zero_o <= pin_nxt;
			output_pin_one_o <= (ctrl1_r.mode == CTM_MODE_CMP || ctrl1_r.mode == CTM_MODE_PWM) ?
				~pin_nxt : 1'b0;
			match_flags_o <= {p_flag_r, a_flag_r};
		end
	end

	// Control registers and compare A commit
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl0_r <= CTM_RST_CTRL0;
			ctrl1_r <= CTM_RST_CTRL1;
			cmpa_r <= CTM_RST_CMPA;
		end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
			if (is_reg(wb_adr_i, CTM_OFF_CTRL0)) begin
				ctrl0_r <= wb_dat_i[7:0];
			end
			if (is_reg(wb_adr_i, CTM_OFF_CTRL1)) begin
				ctrl1_r <= wb_dat_i[7:0];
			end
			// high write commits buffered low byte
			if (is_reg(wb_adr_i, CTM_OFF_CMPAH)) begin
				cmpa_r <= {wb_dat_i[1:0], cmpa_buf_r};
			end
		end
	end

	// Low byte buffers; unordered access returns stale bytes by design
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_buf_r <= 8'h00;
			cmpa_buf_r <= 8'h00;
		end else if (bus_req) begin
			// low write or high read fills buffer
			if (wb_we_i && wb_sel_i[0] && is_reg(wb_adr_i, CTM_OFF_CMPAL)) begin
				cmpa_buf_r <= wb_dat_i[7:0];
			end else if (!wb_we_i && is_reg(wb_adr_i, CTM_OFF_CMPAH)) begin
				cmpa_buf_r <= cmpa_r[7:0];
			end
			if (!wb_we_i && is_reg(wb_adr_i, CTM_OFF_CNTH)) begin
				cnt_buf_r <= cnt_r[7:0];
			end
		end
	end

	// Read data selection; unmapped words read as zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (wb_adr_i[4:2])
			CTM_OFF_CTRL0[4:2]: rd_nxt[7:0] = ctrl0_r;
			CTM_OFF_CTRL1[4:2]: rd_nxt[7:0] = ctrl1_r;
			CTM_OFF_CNTL[4:2]: rd_nxt[7:0] = cnt_buf_r;
			CTM_OFF_CNTH[4:2]: rd_nxt[1:0] = cnt_r[9:8];
			CTM_OFF_CMPAL[4:2]: rd_nxt[7:0] = cmpa_buf_r;
			CTM_OFF_CMPAH[4:2]: rd_nxt[1:0] = cmpa_r[9:8];
			CTM_OFF_STAT[4:2]: rd_nxt[1:0] = {p_flag_r, a_flag_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// Bus answer: one wait state, ack for a single cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? rd_nxt : 32'h0000_0000;
		end
	end

	// Enable rising in the register
	sequence s_on_rise;
		!ctrl0_r.on ##1 ctrl0_r.on;
	endsequence
	property p_on_rise_clears;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_on_rise |=> (cnt_r == 10'h000);
	endproperty
	a_on_rise_clears: assert property (p_on_rise_clears)
		else $error("counter not cleared after enable rise");
	property p_off_holds;
		@(posedge clk_i) disable iff (!rst_n_i)
		!ctrl0_r.on |=> $stable(cnt_r);
	endproperty
	a_off_holds: assert property (p_off_holds)
		else $error("counter moved while off");
	property p_pause_holds;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl0_r.pause && !on_rise) |=> $stable(cnt_r);
	endproperty
	a_pause_holds: assert property (p_pause_holds)
		else $error("counter moved while paused");
	property p_no_clock_code;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl0_r.clk_sel == CTM_CK_NONE && !on_rise) |=> $stable(cnt_r);
	endproperty
	a_no_clock_code: assert property (p_no_clock_code)
		else $error("counter moved with undefined clock");
	property p_count_step;
		@(posedge clk_i) disable iff (!rst_n_i)
		(run && !clr) |=> (cnt_r == $past(cnt_r) + 10'h001);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step by one");
	property p_p_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl1_r.mode == CTM_MODE_CMP && !ctrl1_r.clear_sel && p_hit) |=>
			(cnt_r == 10'h000) ##1 p_flag_r;
	endproperty
	a_p_clear: assert property (p_p_clear)
		else $error("P match did not clear counter");
	property p_a_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl1_r.mode != CTM_MODE_PWM && ctrl1_r.clear_sel && a_hit) |=>
			(cnt_r == 10'h000) && a_flag_r;
	endproperty
	a_a_clear: assert property (p_a_clear)
		else $error("A match did not clear counter");
	property p_toggle;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl1_r.mode == CTM_MODE_CMP && ctrl1_r.action == CTM_IO_TOGGLE && a_hit && !on_rise)
			|=> (lvl_r != $past(lvl_r)) ##1 (output_pin_zero_o == ($past(lvl_r) ^ ctrl1_r.invert));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("pin did not toggle on A match");
	property p_timer_pin_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl1_r.mode == CTM_MODE_TMR) |=> !output_pin_zero_o;
	endproperty
	a_timer_pin_low: assert property (p_timer_pin_low)
		else $error("pin driven in timer mode");
endmodule : ctm_top
`default_nettype wire

// File: bench/ctm_ext_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side source for the external count pin
module ctm_ext_model (
	// Clock
	input wire logic clk_i,
	// Count pin
	output logic pin_o
);
	// Pin rests low between bursts
	initial pin_o = 1'b0;
	// Whole pulses only, so each burst has as many rises as falls
	// two slow edges per pulse
	task automatic send(input int n, input int w);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			pin_o <= 1'b1;
			repeat (w) @(posedge clk_i);
			pin_o <= 1'b0;
			repeat (w) @(posedge clk_i);
		end
	endtask : send
endmodule : ctm_ext_model
`default_nettype wire

// File: bench/ctm_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ctm_top_tb;
	import ctm_pkg::*;
	// Clock, reset and bus
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
	logic [4:0] wb_adr = 5'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	// Count sources and pins
	logic hs_tick = 1'b0, tb_tick = 1'b0, ext, pin0, pin1;
	logic [1:0] tb_div = 2'h0, flags;
	int seed = 1;
	int miscompares = 0;
	int samples_checked = 0;
	logic [7:0] q, r;
	logic [9:0] va, v1, v2, hi;
	always #12.5 clk_i = ~clk_i;
	// High-speed enable every other cycle, timebase every fourth
	always @(posedge clk_i) begin
		hs_tick <= ~hs_tick;
		tb_div <= tb_div + 2'h1;
		tb_tick <= (tb_div == 2'h3);
	end
	ctm_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .hs_tick_i(hs_tick), .tb_tick_i(tb_tick),
		.external_count_input_i(ext), .output_pin_zero_o(pin0), .output_pin_one_o(pin1),
		.match_flags_o(flags));
	ctm_ext_model ext_u (.clk_i(clk_i), .pin_o(ext));
	task automatic complete_run();
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Classic cycle: hold everything until ack is sampled high
	task automatic wb_io(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		q = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 20) miscompares++;
	endtask : wb_io
	task automatic wb_wr(input logic [4:0] a, input logic [7:0] d);
		wb_io(1'b1, a, d);
	endtask : wb_wr
	// High byte first so the low byte comes from the latch
	task automatic rd10(input logic [4:0] ah, output logic [9:0] v);
		wb_io(1'b0, ah, 8'h00);
		v[9:8] = q[1:0];
		wb_io(1'b0, ah - 5'h04, 8'h00);
		v[7:0] = q;
	endtask : rd10
	// Stop, clear flags, then restart from zero
	task automatic run(input logic [2:0] s, input logic [2:0] p);
		wb_wr(CTM_OFF_CTRL0, 8'h00);
		wb_wr(CTM_OFF_STAT, 8'h03);
		wb_wr(CTM_OFF_CTRL0, {1'b0, s, 1'b1, p});
	endtask : run
	task automatic wflag(input int b, input int lim);
		int n;
		n = 0;
		while (flags[b] !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk("flag", 10'h1, {9'h0, flags[b]});
	endtask : wflag
	function automatic int exp_cnt(input logic [2:0] s, input int c);
		case (s)
			CTM_CK_SYS4, CTM_CK_TB: return c / 4;
			CTM_CK_SYS: return c;
			CTM_CK_HS16: return c / 32;
			CTM_CK_HS64: return c / 128;
			default: return 0;
		endcase
	endfunction : exp_cnt
	function automatic logic near(input logic [9:0] v, input int e, input int t);
		return (int'(v) >= e - t) && (int'(v) <= e + t);
	endfunction : near
	function automatic logic exp_pin(input logic [1:0] a, input logic init);
		case (a)
			CTM_IO_KEEP: return init;
			CTM_IO_LOW: return 1'b0;
			CTM_IO_HIGH: return 1'b1;
			default: return !init;
		endcase
	endfunction : exp_pin
	// Watchdog well beyond the expected run length
	initial begin
		#(25 * 60000);
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Every register and the unmapped slot read zero
		for (int i = 0; i < 8; i++) begin
			wb_io(1'b0, 5'(i * 4), 8'h00);
			chk("reset", 10'h0, {2'h0, q});
		end
		// Counter is read only
		wb_wr(CTM_OFF_CNTH, 8'h03);
		rd10(CTM_OFF_CNTH, v1);
		chk("cnt_ro", 10'h0, v1);
		va = 10'($random(seed));
		wb_wr(CTM_OFF_CMPAL, va[7:0]);
		wb_wr(CTM_OFF_CMPAH, {6'h0, va[9:8]});
		rd10(CTM_OFF_CMPAH, v1);
		chk("cmpa", va, v1);
		// A lone low write stays in the buffer
		wb_wr(CTM_OFF_CMPAL, ~va[7:0]);
		rd10(CTM_OFF_CMPAH, v1);
		chk("cmpa_buf", va, v1);
		for (int s = 0; s < 6; s++) begin
			run(3'(s), 3'h0);
			repeat (800) @(posedge clk_i);
			wb_wr(CTM_OFF_CTRL0, {1'b0, 3'(s), 4'h0});
			rd10(CTM_OFF_CNTH, v1);
			chk("src_cnt", 10'h1, {9'h0, near(v1, exp_cnt(3'(s), 800), 3)});
		end
		for (int e = 6; e < 8; e++) begin
			r = 8'h01 + 8'($random(seed) & 15);
			run(3'(e), 3'h0);
			ext_u.send(int'(r), 3 + ($random(seed) & 3));
			wb_wr(CTM_OFF_CTRL0, 8'h00);
			rd10(CTM_OFF_CNTH, v1);
			chk("ext_cnt", {2'h0, r}, v1);
		end
		run(3'h1, 3'h0);
		repeat (50) @(posedge clk_i);
		wb_wr(CTM_OFF_CTRL0, 8'h98);
		rd10(CTM_OFF_CNTH, v1);
		repeat (30) @(posedge clk_i);
		rd10(CTM_OFF_CNTH, v2);
		chk("pause", v1, v2);
		wb_wr(CTM_OFF_CTRL0, 8'h18);
		repeat (20) @(posedge clk_i);
		wb_wr(CTM_OFF_CTRL0, 8'h10);
		rd10(CTM_OFF_CNTH, v1);
		chk("resume", 10'h1, {9'h0, near(v1, int'(v2) + 22, 3)});
		wb_wr(CTM_OFF_CTRL0, 8'h58);
		rd10(CTM_OFF_CNTH, v1);
		chk("on_clr", 10'h0, v1);
		// P span 128, then code zero overflows at 1024
		for (int p = 1; p >= 0; p--) begin
			wb_wr(CTM_OFF_CTRL0, 8'h00);
			wb_wr(CTM_OFF_CTRL1, 8'h00);
			run(3'h1, 3'(p));
			repeat (p ? 118 : 1014) @(posedge clk_i);
			chk("flagp_early", 10'h0, {9'h0, flags[1]});
			wflag(1, 24);
		end
		wb_wr(CTM_OFF_CMPAL, 8'h04);
		wb_wr(CTM_OFF_CMPAH, 8'h01);
		// Every action with random initial level and inversion
		for (int a = 0; a < 4; a++) begin
			r = 8'($random(seed));
			wb_wr(CTM_OFF_CTRL0, 8'h00);
			wb_wr(CTM_OFF_CTRL1, {2'b00, 2'(a), r[0], r[1], 2'b01});
			run(3'h1, 3'h1);
			repeat (8) @(posedge clk_i);
			chk("pin0_init", {9'h0, r[0] ^ r[1]}, {9'h0, pin0});
			chk("pin1_init", {9'h0, !(r[0] ^ r[1])}, {9'h0, pin1});
			wflag(0, 300);
			repeat (3) @(posedge clk_i);
			chk("pin0_act", {9'h0, exp_pin(2'(a), r[0]) ^ r[1]}, {9'h0, pin0});
			chk("flagp_off", 10'h0, {9'h0, flags[1]});
		end
		// Mode changes only while stopped; timer and undefined modes leave pins low
		for (int m = 0; m < 2; m++) begin
			wb_wr(CTM_OFF_CTRL0, 8'h00);
			wb_wr(CTM_OFF_CTRL1, m ? 8'h7e : 8'hfe);
			run(3'h1, 3'h1);
			repeat (300) @(posedge clk_i);
			chk("tmr_pin", 10'h0, {8'h0, pin1, pin0});
			// Flags still come as in compare mode
			chk("tmr_flag", 10'h1, {9'h0, flags[1]});
		end
		for (int d = 0; d < 2; d++) begin
			wb_wr(CTM_OFF_CTRL0, 8'h00);
			wb_wr(CTM_OFF_CTRL1, {6'b101010, 1'(d), 1'b0});
			wb_wr(CTM_OFF_CMPAL, d ? 8'h00 : 8'h20);
			wb_wr(CTM_OFF_CMPAH, d ? 8'h01 : 8'h00);
			run(3'h1, 3'h1);
			repeat (600) @(posedge clk_i);
			hi = 10'h0;
			for (int i = 0; i < (d ? 512 : 256); i++) begin
				@(posedge clk_i);
				hi = hi + {9'h0, pin0};
			end
			chk("pwm_hi", d ? 10'h100 : 10'h040, hi);
		end
		// Forced levels; the undefined action code rests at the inactive level
		for (int a = 0; a < 4; a++) begin
			if (a != 2) begin
				wb_wr(CTM_OFF_CTRL0, 8'h00);
				wb_wr(CTM_OFF_CTRL1, {2'b10, 2'(a), 4'b1000});
				run(3'h1, 3'h1);
				repeat (20) @(posedge clk_i);
				chk("pwm_force", {9'h0, 1'(a == 1)}, {9'h0, pin0});
			end
		end
		complete_run();
	end
endmodule : ctm_top_tb
`default_nettype wire
